// ---- hw/vdr_regs.sv ----
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - keep mode settings and capture the device's operating results in registers.
// - route status functions out and control functions in over the I/O pins.
// - power-on pin map: crc 5, fifo empty 6, lock 4, eav 7, h 2, v 1.
// - every one-bit flag is positive logic, set reads as one.
// - error flags read-only and cleared at reset; edh force off, enable on.
// - ancillary id resets 0000h, mask ffffh, fifo empty set, other fifo flags clear.
// - sync position, sav and eav are read-only and routable to pins.
// - six-bit pattern select resets to zero, generator off, pass/fail read-only.
// - crc replace, unscrambled and external video clock start off.
// - fifo depth, format set, reference clock and pin map reset as documented.
// - reset loads its defaults into all latches and registers of the bank.
module vdr_regs
	import vdr_pkg::*;
#(
	parameter int PINS = PIN_COUNT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// device side
	input wire vdr_stat_s stat_in,
	output vdr_cfg_s ctl,
	output logic irq,
	// multi-function pins
	input wire logic [7:0] io_in,
	output logic [7:0] io_out,
	output logic [7:0] io_oe
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		vdr_cfg_s cfg;
		vdr_cfg_s eff;
		vdr_stat_s st;
		logic [7:0] sticky;
		logic [7:0] sync1, sync2;
		logic [7:0] rdata, io_out, io_oe;
		logic irq;
	} vdr_state_s;

	vdr_state_s s;
	vdr_state_s next_s;
	logic [21:0] fn_vec;
	logic [7:0] ev;

	// the pin mux is sized for eight pins and 6-bit codes only
	if (PINS != 8) begin : g_pins_check
		$error("vdr_regs serves exactly eight multi-function pins");
	end

	// status functions in pin-code order; taken from the input itself
	// so the comb block does not read back what it writes
	assign fn_vec = {stat_in.format[4], stat_in.pass_fail,
		stat_in.lock, stat_in.eav, stat_in.sav,
		stat_in.new_sync_position_flag, stat_in.f, stat_in.v,
		stat_in.h, stat_in.short_msg, stat_in.full_msg,
		stat_in.fifo_overrun, stat_in.fifo_full, stat_in.fifo_90,
		stat_in.fifo_empty, stat_in.cksum_err, stat_in.anc_err,
		stat_in.ap_err, stat_in.ff_err, stat_in.crc_chroma,
		stat_in.crc_luma, stat_in.crc_err};

	// interrupt events: rising edges of error and status flags, and loss of lock
	assign ev = {stat_in.pass_fail & ~s.st.pass_fail,
		s.st.lock & ~stat_in.lock,
		stat_in.new_sync_position_flag & ~s.st.new_sync_position_flag,
		stat_in.fifo_full & ~s.st.fifo_full,
		stat_in.fifo_overrun & ~s.st.fifo_overrun,
		stat_in.cksum_err & ~s.st.cksum_err,
		(stat_in.ff_err | stat_in.ap_err | stat_in.anc_err) &
			~(s.st.ff_err | s.st.ap_err | s.st.anc_err),
		stat_in.crc_err & ~s.st.crc_err};

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		next_s = s;
		// status is captured straight from the device, so a host write
		// has no path into it
		next_s.st = stat_in;
		next_s.sync1 = io_in;
		next_s.sync2 = s.sync1;
		// register writes; read-only fields are simply not decoded
		if (wr) begin
			unique case (addr)
				EDH0_ADDR: begin
					next_s.cfg.edh_force = wdata[6];
					next_s.cfg.edh_enable = wdata[5];
				end
				EDH1_ADDR: next_s.cfg.crc_replace = wdata[7];
				ANC0_ADDR: begin
					next_s.cfg.vfifo_depth = wdata[7:5];
					next_s.cfg.cksum_force = wdata[0];
				end
				ANC1_ADDR: next_s.cfg.anc_id[7:0] = wdata;
				ANC2_ADDR: next_s.cfg.anc_id[15:8] = wdata;
				ANC3_ADDR: next_s.cfg.anc_mask[7:0] = wdata;
				ANC4_ADDR: next_s.cfg.anc_mask[15:8] = wdata;
				ANC5_ADDR: begin
					next_s.cfg.extract_en = wdata[7];
					next_s.cfg.fifo_clk_en = wdata[6];
					next_s.cfg.fifo_flush_static = wdata[3];
					next_s.cfg.msg_flush_static = wdata[1];
					next_s.cfg.msg_track = wdata[0];
				end
				FMT0_ADDR: begin
					next_s.cfg.sd_only = wdata[7];
					next_s.cfg.hd_only = wdata[6];
					next_s.cfg.framing_mode = wdata[5];
					next_s.cfg.fmt_set = wdata[4:0];
				end
				TEST0_ADDR: begin
					next_s.cfg.tpg_en = wdata[6];
					next_s.cfg.tp_sel = wdata[5:0];
				end
				VINFO0_ADDR: begin
					next_s.cfg.vdedither = wdata[7];
					next_s.cfg.bar_filter_enable = wdata[6];
					next_s.cfg.dedither = wdata[5];
					next_s.cfg.framing_en = wdata[3];
				end
				VCTL0_ADDR: begin
					next_s.cfg.ext_vclk = wdata[7];
					next_s.cfg.sync_det = wdata[3];
					next_s.cfg.lsb_clip = wdata[2];
					next_s.cfg.nrzi = wdata[1];
					next_s.cfg.descramble = wdata[0];
				end
				VCTL1_ADDR: next_s.cfg.unscrambled = wdata[0];
				REFCLK_ADDR: next_s.cfg.ref_clk = wdata[7:6];
				INT_MASK_ADDR: next_s.cfg.int_mask = wdata;
				default: begin
					if (addr >= PIN0_ADDR && addr < ANC5_ADDR) begin
						next_s.cfg.pin_sel[3'(addr - PIN0_ADDR)] =
							wdata[7:2];
					end
				end
			endcase
		end
		// read data stand only in the cycle after the strobe
		next_s.rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				EDH0_ADDR: next_s.rdata = {s.st.crc_err, s.cfg.edh_force,
					s.cfg.edh_enable, s.st.ff_flags};
				EDH1_ADDR: next_s.rdata = {s.cfg.crc_replace,
					s.st.crc_luma, s.st.crc_chroma, s.st.ap_flags};
				EDH2_ADDR: next_s.rdata = {s.st.ff_err, s.st.ap_err,
					s.st.anc_err, s.st.anc_flags};
				ANC0_ADDR: next_s.rdata = {s.cfg.vfifo_depth,
					s.st.fifo_overrun, s.st.fifo_empty, s.st.fifo_full,
					s.st.cksum_err, s.cfg.cksum_force};
				ANC1_ADDR: next_s.rdata = s.cfg.anc_id[7:0];
				ANC2_ADDR: next_s.rdata = s.cfg.anc_id[15:8];
				ANC3_ADDR: next_s.rdata = s.cfg.anc_mask[7:0];
				ANC4_ADDR: next_s.rdata = s.cfg.anc_mask[15:8];
				ANC5_ADDR: next_s.rdata = {s.cfg.extract_en,
					s.cfg.fifo_clk_en, s.st.full_msg, 1'b0,
					s.cfg.fifo_flush_static, 1'b0,
					s.cfg.msg_flush_static, s.cfg.msg_track};
				ANC6_ADDR: next_s.rdata = {s.st.fifo_90, s.st.short_msg,
					6'h00};
				FMT0_ADDR: next_s.rdata = {s.cfg.sd_only, s.cfg.hd_only,
					s.cfg.framing_mode, s.cfg.fmt_set};
				FMT1_ADDR: next_s.rdata = {s.st.format, s.st.h, s.st.v,
					s.st.f};
				TEST0_ADDR: next_s.rdata = {s.st.pass_fail, s.cfg.tpg_en,
					s.cfg.tp_sel};
				VINFO0_ADDR: next_s.rdata = {s.cfg.vdedither,
					s.cfg.bar_filter_enable, s.cfg.dedither, s.st.lock,
					s.cfg.framing_en, s.st.sav,
					s.st.new_sync_position_flag, s.st.eav};
				VCTL0_ADDR: next_s.rdata = {s.cfg.ext_vclk, 3'h0,
					s.cfg.sync_det, s.cfg.lsb_clip, s.cfg.nrzi,
					s.cfg.descramble};
				VCTL1_ADDR: next_s.rdata = {7'h00, s.cfg.unscrambled};
				REFCLK_ADDR: next_s.rdata = {s.cfg.ref_clk, 6'h00};
				INT_STAT_ADDR: next_s.rdata = s.sticky;
				INT_MASK_ADDR: next_s.rdata = s.cfg.int_mask;
				default: begin
					if (addr >= PIN0_ADDR && addr < ANC5_ADDR) begin
						next_s.rdata = {s.cfg.pin_sel[3'(addr - PIN0_ADDR)],
							2'b00};
					end
				end
			endcase
		end
		// read clears the sticky bits, but a new event wins
		if (rd && addr == INT_STAT_ADDR) begin
			next_s.sticky = 8'h00;
		end
		next_s.sticky = next_s.sticky | ev;
		next_s.irq = |(next_s.sticky & next_s.cfg.int_mask);
		// pins: output functions drive, input functions override a bit
		next_s.eff = next_s.cfg;
		for (int k = 0; k < 8; k++) begin
			next_s.io_oe[k] = next_s.cfg.pin_sel[k] < NUM_OUT_FN;
			next_s.io_out[k] = 1'b0;
			if (next_s.io_oe[k]) begin
				next_s.io_out[k] = fn_vec[5'(next_s.cfg.pin_sel[k])];
			end
			unique case (next_s.cfg.pin_sel[k] ^ IN_FN_BASE)
				6'h00: next_s.eff.edh_force = s.sync2[k];
				6'h01: next_s.eff.edh_enable = s.sync2[k];
				6'h02: next_s.eff.cksum_force = s.sync2[k];
				6'h03: next_s.eff.extract_en = s.sync2[k];
				6'h04: next_s.eff.framing_en = s.sync2[k];
				6'h05: next_s.eff.dedither = s.sync2[k];
				6'h06: next_s.eff.vdedither = s.sync2[k];
				6'h07: next_s.eff.tpg_en = s.sync2[k];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	// reset loads documented defaults; ce low freezes the whole bank
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '{cfg: CFG_RST, eff: CFG_RST, st: STAT_RST,
				default: '0};
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign ctl = s.eff;
	assign irq = s.irq;
	assign io_out = s.io_out;
	assign io_oe = s.io_oe;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	reset_defaults_a: assert property ($fell(rst) |->
		s.cfg.edh_enable && !s.cfg.edh_force && s.st == STAT_RST &&
		s.cfg.anc_mask == 16'hffff && s.cfg.anc_id == 16'h0000)
		else $error("bank reset values wrong");
	reset_map_a: assert property ($fell(rst) |->
		s.cfg.pin_sel == PIN_SEL_RST && s.cfg.tp_sel == 6'h00 &&
		!s.cfg.tpg_en && !s.cfg.crc_replace && !s.cfg.ext_vclk)
		else $error("pin map or test defaults wrong");
	reset_misc_a: assert property ($fell(rst) |->
		s.cfg.vfifo_depth == 3'h0 && s.cfg.fmt_set == 5'h00 &&
		s.cfg.ref_clk == 2'h0 && !s.cfg.unscrambled)
		else $error("format or clock defaults wrong");
	ro_ignore_a: assert property (ce && wr |=>
		s.st == $past(stat_in))
		else $error("status altered by host write");
	test_write_a: assert property (ce && wr && addr == TEST0_ADDR |=>
		s.cfg.tp_sel == $past(wdata[5:0]) &&
		s.cfg.tpg_en == $past(wdata[6]))
		else $error("pattern select not stored");
	sync_read_a: assert property (ce && rd && addr == VINFO0_ADDR
		|=> rdata[1] == $past(s.st.new_sync_position_flag))
		else $error("sync position readback wrong");
	pin_drive_a: assert property (ce |=> io_oe[5] ==
		(s.cfg.pin_sel[5] < NUM_OUT_FN))
		else $error("pin enable does not follow map");
	irq_level_a: assert property (irq == |(s.sticky & s.cfg.int_mask))
		else $error("interrupt level wrong");
	sticky_set_a: assert property (ce && stat_in.crc_err && !s.st.crc_err
		|=> s.sticky[0] && (irq || !s.cfg.int_mask[0]))
		else $error("crc event lost");

	// outputs come up quiet; the pin map only drives after one ce edge
	reset_io_a: assert property ($fell(rst) |->
		io_oe == 8'h00 && io_out == 8'h00 && !irq && rdata == 8'h00)
		else $error("outputs not quiet after reset");
	rdata_idle_a: assert property (ce && !rd |=>
		rdata == 8'h00)
		else $error("read data outside read slot");
	sticky_clear_a: assert property (ce && rd && addr == INT_STAT_ADDR
		|=> s.sticky == $past(ev))
		else $error("status read did not clear");
	lock_loss_a: assert property (ce && s.st.lock && !stat_in.lock
		|=> s.sticky[6])
		else $error("lock loss not recorded");
	refclk_write_a: assert property (ce && wr && addr == REFCLK_ADDR
		|=> s.cfg.ref_clk == $past(wdata[7:6]))
		else $error("reference clock select not stored");
	// a write in the same cycle could move the map, so leave it out
	pin_out_a: assert property (ce && !wr && s.cfg.pin_sel[5] == FN_CRC_ERR
		|=> io_out[5] == $past(stat_in.crc_err))
		else $error("crc flag not on its pin");

endmodule

// ---- shared/vdr_pkg.sv ----
package vdr_pkg;

	// ************************************************************
	// register offsets (byte index on the 8-bit control port)
	// ************************************************************
	localparam logic [7:0] EDH0_ADDR = 8'h01;
	localparam logic [7:0] EDH1_ADDR = 8'h02;
	localparam logic [7:0] EDH2_ADDR = 8'h03;
	localparam logic [7:0] ANC0_ADDR = 8'h04;
	localparam logic [7:0] ANC1_ADDR = 8'h05;
	localparam logic [7:0] ANC2_ADDR = 8'h06;
	localparam logic [7:0] ANC3_ADDR = 8'h07;
	localparam logic [7:0] ANC4_ADDR = 8'h08;
	localparam logic [7:0] ANC5_ADDR = 8'h17;
	localparam logic [7:0] ANC6_ADDR = 8'h18;
	localparam logic [7:0] FMT0_ADDR = 8'h0b;
	localparam logic [7:0] FMT1_ADDR = 8'h0c;
	localparam logic [7:0] TEST0_ADDR = 8'h0d;
	localparam logic [7:0] VINFO0_ADDR = 8'h0e;
	localparam logic [7:0] PIN0_ADDR = 8'h0f;
	localparam logic [7:0] VCTL0_ADDR = 8'h55;
	localparam logic [7:0] VCTL1_ADDR = 8'h56;
	localparam logic [7:0] REFCLK_ADDR = 8'h67;
	localparam logic [7:0] INT_STAT_ADDR = 8'h70;
	localparam logic [7:0] INT_MASK_ADDR = 8'h71;

	// ************************************************************
	// multi-function pin codes
	// ************************************************************
	localparam int PIN_COUNT = 8;
	localparam logic [5:0] NUM_OUT_FN = 6'h16; // codes below drive out
	localparam logic [5:0] IN_FN_BASE = 6'h20; // codes 20h..27h are inputs
	localparam logic [5:0] FN_CRC_ERR = 6'h00;
	localparam logic [5:0] FN_FIFO_EMPTY = 6'h07;
	localparam logic [5:0] FN_H = 6'h0d;
	localparam logic [5:0] FN_V = 6'h0e;
	localparam logic [5:0] FN_F = 6'h0f;
	localparam logic [5:0] FN_EAV = 6'h12;
	localparam logic [5:0] FN_LOCK = 6'h13;
	localparam logic [5:0] FN_FORMAT4 = 6'h15;
	localparam logic [7:0][5:0] PIN_SEL_RST = {FN_EAV, FN_FIFO_EMPTY,
		FN_CRC_ERR, FN_LOCK, FN_FORMAT4, FN_H, FN_V, FN_F};

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic edh_force, edh_enable, crc_replace, cksum_force;
		logic [15:0] anc_id;
		logic [15:0] anc_mask;
		logic msg_track, msg_flush_static, fifo_flush_static;
		logic fifo_clk_en, extract_en;
		logic [2:0] vfifo_depth;
		logic [4:0] fmt_set;
		logic sd_only, hd_only, framing_mode, framing_en;
		logic descramble, nrzi, lsb_clip, sync_det;
		logic dedither, vdedither, unscrambled;
		logic [5:0] tp_sel;
		logic tpg_en, bar_filter_enable;
		logic [1:0] ref_clk;
		logic ext_vclk;
		logic [7:0][5:0] pin_sel;
		logic [7:0] int_mask;
	} vdr_cfg_s;

	typedef struct packed {
		logic crc_err, crc_luma, crc_chroma;
		logic [4:0] ff_flags, ap_flags, anc_flags;
		logic ff_err, ap_err, anc_err, cksum_err;
		logic fifo_empty, fifo_90, fifo_full, fifo_overrun;
		logic full_msg, short_msg;
		logic [4:0] format;
		logic h, v, f, new_sync_position_flag, sav, eav, lock, pass_fail;
	} vdr_stat_s;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam vdr_cfg_s CFG_RST = '{edh_enable: 1'b1,
		anc_mask: 16'hffff, framing_mode: 1'b1, framing_en: 1'b1,
		descramble: 1'b1, nrzi: 1'b1, lsb_clip: 1'b1, sync_det: 1'b1,
		pin_sel: PIN_SEL_RST, default: '0};
	localparam vdr_stat_s STAT_RST = '{fifo_empty: 1'b1, default: '0};

endpackage

// ---- verif/vdr_regs_test.sv ----
`timescale 1ns/1ps
module vdr_regs_test;
	import vdr_pkg::*;
	logic clk = 0, rst = 1, ce = 1, wr = 0, rd = 0, rd_seen = 0, irq;
	logic [7:0] addr = '0, wdata = '0, ext = '0, d, rdata, io_out, io_oe;
	logic [7:0] io_in;
	vdr_stat_s want = STAT_RST, stat_in;
	vdr_cfg_s ctl;
	int fails = 0, checks_done = 0, seed = 28;
	logic [7:0] expq[$];
	logic [7:0] ra[19] = '{EDH0_ADDR, EDH1_ADDR, EDH2_ADDR, ANC0_ADDR,
		ANC1_ADDR, ANC2_ADDR, ANC3_ADDR, ANC4_ADDR, ANC5_ADDR, ANC6_ADDR,
		FMT0_ADDR, FMT1_ADDR, TEST0_ADDR, VCTL0_ADDR, VCTL1_ADDR,
		REFCLK_ADDR, INT_STAT_ADDR, INT_MASK_ADDR, 8'h40};
	logic [7:0] rv[19] = '{8'h20, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00,
		8'hff, 8'hff, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h0f, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};

	// 200 MHz clock
	always #2.5 clk = ~clk;

	vdr_regs uut (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.stat_in(stat_in), .ctl(ctl), .irq(irq), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe));
	vdr_stat_model far (.clk(clk), .want(want), .ext_drive(ext),
		.io_out(io_out), .io_oe(io_oe), .stat_in(stat_in), .io_in(io_in));

	// ************************************************************
	// checking
	// ************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// read data stands only the cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen) begin
			if (expq.size() == 0) chk(rdata, 8'hxx);
			else chk(rdata, expq.pop_front());
		end
		rd_seen <= rd;
	end

	task automatic end_of_test;
		if (fails == 0 && checks_done > 0 && expq.size() == 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// a one-cycle gap between strobes keeps each task self-contained
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		expq.push_back(x);
		@(posedge clk);
		rd <= 0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		idle(2);
		rst <= 0;
		for (int i = 0; i < 19; i++) rreg(ra[i], rv[i]);
		for (int i = 0; i < 8; i++)
			rreg(PIN0_ADDR + 8'(i), {PIN_SEL_RST[i], 2'b00});
		// power-on pin map seen at the pins themselves
		@(posedge clk) want <= '{crc_err: 1'b1, fifo_empty: 1'b1, h: 1'b1,
			f: 1'b1, lock: 1'b1, eav: 1'b1,
			new_sync_position_flag: 1'b1, default: '0};
		idle(4);
		chk(io_out, 8'hf5);
		chk(io_oe, 8'hff);
		chk({7'h0, irq}, 8'h00);
		rreg(FMT1_ADDR, 8'h05);
		rreg(VINFO0_ADDR, 8'h1b);
		rreg(INT_STAT_ADDR, 8'h21);
		rreg(INT_STAT_ADDR, 8'h00);
		// read-only bits keep captured values under random writes
		repeat (4) begin
			d = 8'($random(seed));
			wreg(EDH0_ADDR, d);
			rreg(EDH0_ADDR, {1'b1, d[6:5], 5'h00});
			wreg(ANC0_ADDR, d);
			rreg(ANC0_ADDR, {d[7:5], 4'b0100, d[0]});
			wreg(TEST0_ADDR, d);
			rreg(TEST0_ADDR, {1'b0, d[6:0]});
			for (int a = 5; a < 9; a++) begin
				wreg(8'(a), d ^ 8'(a));
				rreg(8'(a), d ^ 8'(a));
			end
			wreg(REFCLK_ADDR, d);
			rreg(REFCLK_ADDR, {d[7:6], 6'h00});
			wreg(8'h40, d);
			rreg(8'h40, 8'h00);
		end
		// strobes are ignored while the clock enable is low
		@(posedge clk) ce <= 0;
		wreg(ANC1_ADDR, ~(d ^ 8'h05));
		ce <= 1;
		rreg(ANC1_ADDR, d ^ 8'h05);
		// masked event stays sticky, unmasked one raises irq
		wreg(INT_MASK_ADDR, 8'h01);
		rreg(INT_MASK_ADDR, 8'h01);
		@(posedge clk) want.cksum_err <= 1'b1;
		want.crc_err <= 1'b0;
		idle(4);
		chk({7'h0, irq}, 8'h00);
		rreg(INT_STAT_ADDR, 8'h04);
		@(posedge clk) want.crc_err <= 1'b1;
		idle(4);
		chk({7'h0, irq}, 8'h01);
		rreg(INT_STAT_ADDR, 8'h01);
		idle(2);
		chk({7'h0, irq}, 8'h00);
		// loss of lock is a falling-edge event
		@(posedge clk) want.lock <= 1'b0;
		idle(4);
		rreg(INT_STAT_ADDR, 8'h40);
		// pin 0 turned into a control input for edh force; the register
		// bit is cleared first so only the pin can raise it
		wreg(EDH0_ADDR, 8'h20);
		wreg(PIN0_ADDR, {IN_FN_BASE, 2'b00});
		@(posedge clk) ext <= 8'h01;
		idle(6);
		chk({7'h0, io_oe[0]}, 8'h00);
		chk({7'h0, ctl.edh_force}, 8'h01);
		// a reset in mid-run brings back the defaults
		@(posedge clk) rst <= 1;
		idle(2);
		rst <= 0;
		rreg(ANC1_ADDR, 8'h00);
		rreg(TEST0_ADDR, 8'h00);
		rreg(EDH0_ADDR, 8'ha0);
		idle(3);
		end_of_test();
	end

	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#20000;
		fails++;
		end_of_test();
	end
endmodule

// ---- verif/vdr_stat_model.sv ----
`timescale 1ns/1ps
module vdr_stat_model
	import vdr_pkg::*;
(
	// clock
	input wire logic clk,
	// wanted core status and board pin levels
	input wire vdr_stat_s want,
	input wire logic [7:0] ext_drive,
	// device side
	input wire logic [7:0] io_out,
	input wire logic [7:0] io_oe,
	output vdr_stat_s stat_in,
	output logic [7:0] io_in
);
	// core status moves just after an edge, like the real core
	always @(posedge clk) begin
		stat_in <= want;
	end
	// pin level: the device wins where it drives, else the board
	assign io_in = (io_oe & io_out) | (~io_oe & ext_drive);
endmodule
